// ===== bench/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb import mefr_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] errEvent = 32'h0;
	logic [1:0] flashStart = 2'h0;
	logic flashDone = 1'b0;
	logic [31:0] flashResult = 32'h0;
	logic sectorValid = 1'b0;
	logic [5:0] sectorNum = 6'h00;
	logic [31:0] readdata, errFlags, rd;
	logic waitrequest, flashBusy, flashOpFailed, irq;
	int errors = 0;
	int num_checks = 0;

	mefr_regs i_mefr_regs (.mclk(mclk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .errEvent(errEvent), .flashStart(flashStart),
		.flashDone(flashDone), .flashResult(flashResult), .sectorValid(sectorValid),
		.sectorNum(sectorNum), .errFlags(errFlags), .flashBusy(flashBusy),
		.flashOpFailed(flashOpFailed), .irq(irq));

	always #10 mclk = ~mclk;

	// The request is held until waitrequest is seen low at a rising edge, then released.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do
			@(posedge mclk);
		while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic pulse();
		@(posedge mclk);
		errEvent <= 32'h0;
		flashStart <= 2'h0;
		sectorValid <= 1'b0;
	endtask

	task automatic t_reset();
		rchk(MEFR_OFS_BUSY_CODE, MEFR_BUSY_NONE);
		rchk(MEFR_OFS_OP_RES, MEFR_RESET_VAL);
		rchk(MEFR_OFS_SECTOR, MEFR_RESET_VAL);
		rchk(MEFR_OFS_FLAGS, MEFR_RESET_VAL);
	endtask

	task automatic t_strobes();
		logic [31:0] grp [4] = '{32'h0000_000f, 32'h0000_00f0, 32'h0000_0700, 32'h0007_0000};
		bus(1'b1, MEFR_OFS_SET, 32'hffff_ffff);
		rchk(MEFR_OFS_FLAGS, MEFR_FLAG_MASK);
		bus(1'b1, MEFR_OFS_CLEAR, 32'h0);
		rchk(MEFR_OFS_FLAGS, MEFR_FLAG_MASK);
		`CHK(errFlags, MEFR_FLAG_MASK)
		rchk(MEFR_OFS_SET, 32'h0);
		bus(1'b1, MEFR_OFS_CLEAR, 32'hffff_ffff);
		rchk(MEFR_OFS_CLEAR, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, MEFR_OFS_SET, grp[i]);
			rchk(MEFR_OFS_FLAGS, grp[i]);
			bus(1'b1, MEFR_OFS_CLEAR, grp[i]);
			rchk(MEFR_OFS_FLAGS, 32'h0);
		end
	endtask

	task automatic t_race();
		bus(1'b1, MEFR_OFS_IRQ_STS, 32'h3);
		errEvent <= 32'h0001_0000;
		pulse();
		rchk(MEFR_OFS_IRQ_STS, 32'h1);
		`CHK(irq, 1'b0)
		bus(1'b1, MEFR_OFS_IRQ_MASK, 32'h1);
		@(negedge mclk);
		`CHK(irq, 1'b1)
		bus(1'b1, MEFR_OFS_IRQ_STS, 32'h1);
		@(negedge mclk);
		`CHK(irq, 1'b0)
		// The event lands in the very cycle the clear strobe is high.
		bus(1'b1, MEFR_OFS_CLEAR, 32'h0001_0000);
		errEvent <= 32'h0001_0000;
		pulse();
		rchk(MEFR_OFS_FLAGS, 32'h0001_0000);
		bus(1'b1, MEFR_OFS_CLEAR, 32'h0001_0000);
		rchk(MEFR_OFS_FLAGS, 32'h0);
	endtask

	task automatic t_flash();
		logic [31:0] codes [7] = '{MEFR_RES_SUCCESS, MEFR_RES_MODE_ERR, MEFR_RES_ECC2_ERR,
			MEFR_RES_VERIFY_ERR, MEFR_RES_MAP_ERR, MEFR_RES_VERMAP_ERR, 32'h0000_00d9};
		logic fails [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 7; i++)
		begin
			flashStart <= (i % 2) ? 2'b10 : 2'b01;
			pulse();
			rchk(MEFR_OFS_BUSY_CODE, (i % 2) ? MEFR_BUSY_SECOND : MEFR_BUSY_FIRST);
			`CHK(flashBusy, 1'b1)
			`CHK(flashOpFailed, 1'b0)
			flashDone <= 1'b1;
			flashResult <= codes[i];
			@(posedge mclk);
			flashDone <= 1'b0;
			flashResult <= ~codes[i];
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			`CHK(flashBusy, 1'b0)
			`CHK(flashOpFailed, fails[i])
			rchk(MEFR_OFS_BUSY_CODE, MEFR_BUSY_NONE);
			rchk(MEFR_OFS_OP_RES, codes[i]);
		end
	endtask

	task automatic t_sector();
		sectorNum <= 6'h2a;
		sectorValid <= 1'b1;
		pulse();
		sectorNum <= 6'h15;
		rchk(MEFR_OFS_SECTOR, 32'h0000_002a);
		byteenable <= 4'h1;
		bus(1'b1, MEFR_OFS_SECTOR, 32'hffff_ffff);
		byteenable <= 4'hf;
		rchk(MEFR_OFS_SECTOR, MEFR_SECTOR_MASK);
		bus(1'b1, 8'h80, 32'hffff_ffff);
		rchk(8'h80, 32'h0);
	endtask

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		repeat (20000) @(posedge mclk);
		errors++;
		report_and_stop();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_strobes();
		t_race();
		t_flash();
		t_sector();
		report_and_stop();
	end
endmodule

// ===== src/mefr_pkg.sv
package mefr_pkg;
	localparam logic [7:0] MEFR_OFS_FLAGS = 8'h34;
	localparam logic [7:0] MEFR_OFS_CLEAR = 8'h38;
	localparam logic [7:0] MEFR_OFS_SET = 8'h3c;
	localparam logic [7:0] MEFR_OFS_IRQ_STS = 8'h40;
	localparam logic [7:0] MEFR_OFS_IRQ_MASK = 8'h44;
	localparam logic [7:0] MEFR_OFS_BUSY_CODE = 8'h9c;
	localparam logic [7:0] MEFR_OFS_OP_RES = 8'ha0;
	localparam logic [7:0] MEFR_OFS_SECTOR = 8'ha4;

	localparam logic [31:0] MEFR_RESET_VAL = 32'h0000_0000;
	// Flag layout: first flash 3:0, second flash 7:4, ROM 8, SRAMs 10:9, ECC 18:16.
	localparam logic [31:0] MEFR_FLAG_MASK = 32'h0007_07ff;
	localparam int MEFR_SECTOR_W = 6;
	localparam logic [31:0] MEFR_SECTOR_MASK = 32'h0000_003f;

	localparam logic [31:0] MEFR_BUSY_NONE = 32'h0000_0000;
	localparam logic [31:0] MEFR_BUSY_FIRST = 32'h0000_0001;
	localparam logic [31:0] MEFR_BUSY_SECOND = 32'h0000_0002;

	localparam logic [31:0] MEFR_RES_SUCCESS = 32'h0000_0000;
	localparam logic [31:0] MEFR_RES_MODE_ERR = 32'hffff_ffd9;
	localparam logic [31:0] MEFR_RES_ECC2_ERR = 32'hffff_ffd8;
	localparam logic [31:0] MEFR_RES_VERIFY_ERR = 32'hffff_ffd7;
	localparam logic [31:0] MEFR_RES_MAP_ERR = 32'hffff_ffd6;
	localparam logic [31:0] MEFR_RES_VERMAP_ERR = 32'hffff_ffd5;

	localparam int MEFR_IRQ_ERR = 0;
	localparam int MEFR_IRQ_DONE = 1;
	localparam logic [31:0] MEFR_IRQ_MASK_BITS = 32'h0000_0003;
endpackage

// ===== src/mefr_regs.sv
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
module mefr_regs
	import mefr_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Register bus.
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Error events from the memories.
	input wire logic [31:0] errEvent,
	// Background flash engine.
	input wire logic [1:0] flashStart,
	input wire logic flashDone,
	input wire logic [31:0] flashResult,
	input wire logic sectorValid,
	input wire logic [5:0] sectorNum,
	// Status out.
	output logic [31:0] errFlags,
	output logic flashBusy,
	output logic flashOpFailed,
	output logic irq
);
	logic ack_reg;
	logic [31:0] beMask;
	logic [31:0] wval;
	logic wrEn;
	logic rdLoad;
	logic [31:0] clrStb_reg;
	logic [31:0] setStb_reg;
	logic [31:0] flag_reg;
	logic [31:0] evtM;
	logic [31:0] raise;
	logic [31:0] clrOnly;
	logic [31:0] irqSts_reg;
	logic [31:0] irqMask_reg;
	logic [31:0] irqEvt;
	logic [31:0] busy_reg;
	logic [31:0] result_reg;
	logic [MEFR_SECTOR_W-1:0] sector_reg;
	logic pendIdle_reg;
	logic failed_reg;
	logic [31:0] rdata_reg;
	logic knownCode;

	// Every access takes two cycles; the first one registers read data.
	always_ff @(posedge mclk)
	begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (read | write) & ~ack_reg;
	end

	assign waitrequest = (read | write) & ~ack_reg;
	assign wrEn = write & ack_reg;
	assign rdLoad = read & ~ack_reg;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gLane
			assign beMask[8*g +: 8] = {8{byteenable[g]}};
		end
	endgenerate

	assign wval = writedata & beMask;

	// Strobes live for exactly one cycle after the accepted write.
	always_ff @(posedge mclk)
	begin
		if (rst)
			clrStb_reg <= MEFR_RESET_VAL;
		else if (wrEn && address == MEFR_OFS_CLEAR)
			clrStb_reg <= wval & MEFR_FLAG_MASK;
		else
			clrStb_reg <= MEFR_RESET_VAL;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			setStb_reg <= MEFR_RESET_VAL;
		else if (wrEn && address == MEFR_OFS_SET)
			setStb_reg <= wval & MEFR_FLAG_MASK;
		else
			setStb_reg <= MEFR_RESET_VAL;
	end

	// Events on reserved positions are dropped so those bits stay zero.
	assign evtM = errEvent & MEFR_FLAG_MASK;
	assign raise = setStb_reg | evtM;
	assign clrOnly = clrStb_reg & ~raise;

	// Setting after clearing means a colliding error is never lost.
	always_ff @(posedge mclk)
	begin
		if (rst)
			flag_reg <= MEFR_RESET_VAL;
		else
			flag_reg <= (flag_reg & ~clrStb_reg) | raise;
	end

	assign errFlags = flag_reg;

	// Interrupt sources: a newly raised error flag and a finished operation.
	always_comb
	begin
		irqEvt = MEFR_RESET_VAL;
		irqEvt[MEFR_IRQ_ERR] = |(raise & ~flag_reg);
		irqEvt[MEFR_IRQ_DONE] = flashDone;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			irqSts_reg <= MEFR_RESET_VAL;
		else if (wrEn && address == MEFR_OFS_IRQ_STS)
			irqSts_reg <= (irqSts_reg & ~wval) | irqEvt;
		else
			irqSts_reg <= irqSts_reg | irqEvt;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			irqMask_reg <= MEFR_RESET_VAL;
		else if (wrEn && address == MEFR_OFS_IRQ_MASK)
			irqMask_reg <= ((irqMask_reg & ~beMask) | wval) & MEFR_IRQ_MASK_BITS;
	end

	assign irq = |(irqSts_reg & irqMask_reg);

	// Engine updates take priority over software writes to the same word.
	always_ff @(posedge mclk)
	begin
		if (rst)
			busy_reg <= MEFR_BUSY_NONE;
		else if (flashStart[0])
			busy_reg <= MEFR_BUSY_FIRST;
		else if (flashStart[1])
			busy_reg <= MEFR_BUSY_SECOND;
		else if (pendIdle_reg)
			busy_reg <= MEFR_BUSY_NONE;
		else if (wrEn && address == MEFR_OFS_BUSY_CODE)
			busy_reg <= (busy_reg & ~beMask) | wval;
	end

	// Idle is shown one cycle after the result lands, never earlier.
	always_ff @(posedge mclk)
	begin
		if (rst)
			pendIdle_reg <= 1'b0;
		else
			pendIdle_reg <= flashDone;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			result_reg <= MEFR_RESET_VAL;
		else if (flashDone)
			result_reg <= flashResult;
		else if (wrEn && address == MEFR_OFS_OP_RES)
			result_reg <= (result_reg & ~beMask) | wval;
	end

	always_comb
	begin
		case (result_reg)
			MEFR_RES_SUCCESS,
			MEFR_RES_MODE_ERR,
			MEFR_RES_ECC2_ERR,
			MEFR_RES_VERIFY_ERR,
			MEFR_RES_MAP_ERR,
			MEFR_RES_VERMAP_ERR: knownCode = 1'b1;
			default: knownCode = 1'b0;
		endcase
	end

	// A stale result is still reported in the first cycle of a running operation, then masked until it ends.
	always_ff @(posedge mclk)
	begin
		if (rst)
			failed_reg <= 1'b0;
		else
			failed_reg <= (busy_reg == MEFR_BUSY_NONE) && knownCode
				&& (result_reg != MEFR_RES_SUCCESS);
	end

	assign flashOpFailed = failed_reg;
	assign flashBusy = (busy_reg != MEFR_BUSY_NONE);

	always_ff @(posedge mclk)
	begin
		if (rst)
			sector_reg <= MEFR_RESET_VAL[MEFR_SECTOR_W-1:0];
		else if (sectorValid)
			sector_reg <= sectorNum;
		else if (wrEn && address == MEFR_OFS_SECTOR)
			sector_reg <= (sector_reg & ~beMask[MEFR_SECTOR_W-1:0])
				| wval[MEFR_SECTOR_W-1:0];
	end

	// Strobe registers and unmapped words read as zero.
	always_ff @(posedge mclk)
	begin
		if (rst)
			rdata_reg <= MEFR_RESET_VAL;
		else if (rdLoad)
		begin
			case (address)
				MEFR_OFS_FLAGS: rdata_reg <= flag_reg;
				MEFR_OFS_CLEAR: rdata_reg <= MEFR_RESET_VAL;
				MEFR_OFS_SET: rdata_reg <= MEFR_RESET_VAL;
				MEFR_OFS_IRQ_STS: rdata_reg <= irqSts_reg;
				MEFR_OFS_IRQ_MASK: rdata_reg <= irqMask_reg;
				MEFR_OFS_BUSY_CODE: rdata_reg <= busy_reg;
				MEFR_OFS_OP_RES: rdata_reg <= result_reg;
				MEFR_OFS_SECTOR: rdata_reg <= {26'h0, sector_reg};
				default: rdata_reg <= MEFR_RESET_VAL;
			endcase
		end
	end

	assign readdata = rdata_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	strobe_self_clear_a: assert property (
		(clrStb_reg != 32'h0) || (setStb_reg != 32'h0)
		|=> (clrStb_reg == 32'h0) && (setStb_reg == 32'h0))
		else $error("strobe did not return to zero");

	clear_drops_flag_a: assert property (
		(clrOnly != 32'h0) |=> ((flag_reg & $past(clrOnly)) == 32'h0))
		else $error("cleared flag still set");

	set_wins_a: assert property (
		(raise != 32'h0) |=> ((flag_reg & $past(raise)) == $past(raise)))
		else $error("raised flag lost");

	reserved_zero_a: assert property (
		((flag_reg & ~MEFR_FLAG_MASK) == 32'h0)
		&& ((clrStb_reg & ~MEFR_FLAG_MASK) == 32'h0))
		else $error("reserved bit set");

	strobe_read_a: assert property (
		rdLoad && (address == MEFR_OFS_CLEAR || address == MEFR_OFS_SET)
		|=> (readdata == 32'h0) && !waitrequest)
		else $error("strobe register read nonzero");

	busy_code_a: assert property (
		flashStart[0] |=> (busy_reg == MEFR_BUSY_FIRST) && flashBusy)
		else $error("first flash busy code wrong");

	result_first_a: assert property (
		flashDone && !flashStart[0] && !flashStart[1]
		##1 !flashStart[0] && !flashStart[1]
		|=> (busy_reg == MEFR_BUSY_NONE)
		&& ($past(result_reg) == $past(flashResult, 2)))
		else $error("result not stored before idle");

	sector_load_a: assert property (
		sectorValid |=> (sector_reg == $past(sectorNum)))
		else $error("sector number not captured");

	done_irq_a: assert property (
		flashDone |=> irqSts_reg[MEFR_IRQ_DONE])
		else $error("completion not recorded");

	bus_answer_a: assert property (
		(read || write) && waitrequest ##1 (read || write) |-> !waitrequest)
		else $error("bus answer late");

	clear_first_a: assert property (
		wrEn && (address == MEFR_OFS_CLEAR) |=> (clrStb_reg[3:0] == $past(wval[3:0])))
		else $error("first flash clear strobe wrong");

	clear_second_a: assert property (
		wrEn && (address == MEFR_OFS_CLEAR) |=> (clrStb_reg[7:4] == $past(wval[7:4])))
		else $error("second flash clear strobe wrong");

	clear_prot_a: assert property (
		wrEn && (address == MEFR_OFS_CLEAR) |=> (clrStb_reg[10:8] == $past(wval[10:8])))
		else $error("protection clear strobe wrong");

	clear_ecc_a: assert property (
		wrEn && (address == MEFR_OFS_CLEAR) |=> (clrStb_reg[18:16] == $past(wval[18:16])))
		else $error("single-bit error clear strobe wrong");

	set_first_a: assert property (
		wrEn && (address == MEFR_OFS_SET) |=> (setStb_reg[3:0] == $past(wval[3:0])))
		else $error("first flash set strobe wrong");

	set_second_a: assert property (
		wrEn && (address == MEFR_OFS_SET) |=> (setStb_reg[7:4] == $past(wval[7:4])))
		else $error("second flash set strobe wrong");

	set_prot_a: assert property (
		wrEn && (address == MEFR_OFS_SET) |=> (setStb_reg[10:8] == $past(wval[10:8])))
		else $error("protection set strobe wrong");

	set_ecc_a: assert property (
		wrEn && (address == MEFR_OFS_SET) |=> (setStb_reg[18:16] == $past(wval[18:16])))
		else $error("single-bit error set strobe wrong");

	clear_idle_a: assert property (
		!(wrEn && (address == MEFR_OFS_CLEAR)) |=> (clrStb_reg == 32'h0))
		else $error("clear strobe high without write");

	set_idle_a: assert property (
		!(wrEn && (address == MEFR_OFS_SET)) |=> (setStb_reg == 32'h0))
		else $error("set strobe high without write");

	reserved_set_a: assert property (
		(setStb_reg & ~MEFR_FLAG_MASK) == 32'h0)
		else $error("reserved set strobe bit high");

	reserved_read_a: assert property (
		rdLoad && (address == MEFR_OFS_FLAGS) |=> ((readdata & ~MEFR_FLAG_MASK) == 32'h0))
		else $error("reserved flag bit read nonzero");

	busy_second_a: assert property (
		flashStart[1] && !flashStart[0] |=> (busy_reg == MEFR_BUSY_SECOND))
		else $error("second flash busy code wrong");

	busy_idle_a: assert property (
		pendIdle_reg && (flashStart == 2'b00) |=> (busy_reg == MEFR_BUSY_NONE))
		else $error("busy word not returned to idle");

	result_load_a: assert property (
		flashDone |=> (result_reg == $past(flashResult)))
		else $error("operation result not stored");

	failed_busy_a: assert property (
		flashBusy |=> !flashOpFailed)
		else $error("failure reported while busy");

	failed_code_a: assert property (
		(busy_reg == MEFR_BUSY_NONE) && (result_reg == MEFR_RES_MODE_ERR) |=> flashOpFailed)
		else $error("known error code not reported");

	sector_read_a: assert property (
		rdLoad && (address == MEFR_OFS_SECTOR) |=> (readdata == {26'h0, $past(sector_reg)}))
		else $error("sector word read wrong");

	flag_read_a: assert property (
		rdLoad && (address == MEFR_OFS_FLAGS) |=> (readdata == $past(flag_reg)))
		else $error("flag word read wrong");

	event_wins_a: assert property (
		((evtM & clrStb_reg) != 32'h0)
		|=> ((flag_reg & $past(evtM) & $past(clrStb_reg)) == ($past(evtM) & $past(clrStb_reg))))
		else $error("error event lost to clear");
endmodule
